/* File: sfp_fifo.sv */
`timescale 1ns/10ps
module sfp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Both sides
  sfp_fifo_if.fifo_side q
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic do_push;
  logic do_pop;

  assign q.push_ready = (count != CNT_FULL);
  assign q.pop_valid = (count != '0);
  assign q.pop_data = mem[rd_ptr];
  assign do_push = q.push_valid & q.push_ready;
  assign do_pop = q.pop_valid & q.pop_ready;

  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[wr_ptr] <= q.push_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
      end
      if (do_push && !do_pop) begin
        count <= count + 1'b1;
      end else if (do_pop && !do_push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

/* File: sfp_fifo_if.sv */
`timescale 1ns/10ps
interface sfp_fifo_if #(parameter int WIDTH = 8);
  logic push_valid;
  logic push_ready;
  logic [WIDTH-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [WIDTH-1:0] pop_data;
  modport fifo_side (
    input push_valid, push_data, pop_ready,
    output push_ready, pop_valid, pop_data
  );
  modport user (
    output push_valid, push_data, pop_ready,
    input push_ready, pop_valid, pop_data
  );
endinterface

/* File: sfp_pkg.sv */
package sfp_pkg;
  localparam int DATA_W = 8;
  localparam int RX_FIFO_DEPTH = 32;
  localparam int HALF_W = 4;
  localparam int BIT_CNT_W = 3;
  localparam int EDGE_CNT_W = 4;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;
  localparam logic [EDGE_CNT_W-1:0] LAST_EDGE = 4'hF;
  localparam logic [1:0] RATE_DIV2 = 2'h0;
  localparam logic [1:0] RATE_DIV4 = 2'h1;
  localparam logic [1:0] RATE_DIV16 = 2'h2;
  localparam logic [1:0] RATE_DIV32 = 2'h3;
  localparam logic [HALF_W-1:0] HALF_DIV2 = 4'h0;
  localparam logic [HALF_W-1:0] HALF_DIV4 = 4'h1;
  localparam logic [HALF_W-1:0] HALF_DIV16 = 4'h7;
  localparam logic [HALF_W-1:0] HALF_DIV32 = 4'hF;
  localparam logic RST_CLOCK_POLARITY_BIT = 1'b0;
  localparam logic RST_CLOCK_PHASE_BIT = 1'b1;
  localparam logic [1:0] RST_RATE = 2'h0;
  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
  typedef enum logic [0:0] {
    SFP_IDLE = 1'b0,
    SFP_SHIFT = 1'b1
  } sfp_state_t;
endpackage

/* File: sfp_port.sv */
`timescale 1ns/10ps
module sfp_port #(
  parameter int FIFO_DEPTH = sfp_pkg::RX_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Control register write
  input wire logic ctrl_wr_i,
  input wire logic ctrl_irq_en_i,
  input wire logic ctrl_enable_i,
  input wire logic ctrl_master_i,
  input wire logic ctrl_clock_polarity_bit_i,
  input wire logic ctrl_clock_phase_bit_i,
  input wire logic [1:0] ctrl_rate_i,
  // Control register readback
  output logic irq_en_o,
  output logic enable_o,
  output logic master_o,
  output logic clock_polarity_bit_o,
  output logic clock_phase_bit_o,
  output logic [1:0] rate_o,
  // Status register
  input wire logic status_rd_i,
  output logic done_flag_o,
  output logic collision_flag_o,
  output logic mode_fault_flag_o,
  output logic irq_o,
  // Data register
  input wire logic data_wr_i,
  input wire logic [sfp_pkg::DATA_W-1:0] data_wdata_i,
  input wire logic data_rd_i,
  output logic [sfp_pkg::DATA_W-1:0] data_rdata_o,
  // Received byte stream
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic [sfp_pkg::DATA_W-1:0] rx_data_o,
  // Serial pins
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_o,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_o,
  input wire logic ss_b_i
);
  localparam int W = sfp_pkg::DATA_W;

  function automatic logic [sfp_pkg::HALF_W-1:0] half_limit(input logic [1:0] code);
    case (code)
      sfp_pkg::RATE_DIV2: half_limit = sfp_pkg::HALF_DIV2;
      sfp_pkg::RATE_DIV4: half_limit = sfp_pkg::HALF_DIV4;
      sfp_pkg::RATE_DIV16: half_limit = sfp_pkg::HALF_DIV16;
      default: half_limit = sfp_pkg::HALF_DIV32;
    endcase
  endfunction

  sfp_fifo_if #(.WIDTH(W)) rxq ();

  logic irq_en;
  logic enable;
  logic master;
  logic clock_polarity_bit;
  logic clock_phase_bit;
  logic [1:0] rate;
  logic done_flag;
  logic col_flag;
  logic mode_fault_flag_flag;
  logic arm_done;
  logic arm_col;
  logic arm_mode_fault_flag;
  logic [W-1:0] sh;
  logic [W-1:0] rx_buf;
  logic dout;
  logic sample_bit;
  sfp_pkg::sfp_state_t state;
  logic [sfp_pkg::HALF_W-1:0] half_cnt;
  logic [sfp_pkg::EDGE_CNT_W-1:0] edge_cnt;
  logic sck_lvl;
  logic sck_q;
  logic ss_q;
  logic [sfp_pkg::BIT_CNT_W-1:0] s_bits;
  logic s_busy;

  logic mode_fault_ev;
  logic m_active;
  logic half_tick;
  logic m_lead;
  logic m_trail;
  logic m_last;
  logic s_sel;
  logic s_rise;
  logic s_fall;
  logic s_lead;
  logic s_trail;
  logic s_last;
  logic lead;
  logic trail;
  logic din;
  logic complete;
  logic overrun;
  logic wr_collide;
  logic load;
  logic start;
  logic data_acc;
  logic ss_fall;
  logic [W-1:0] rx_word;

  // Select low while master
  assign mode_fault_ev = master & ~ss_b_i;
  assign m_active = (state == sfp_pkg::SFP_SHIFT);
  assign half_tick = m_active && (half_cnt == half_limit(rate));
  assign m_lead = half_tick & ~edge_cnt[0];
  assign m_trail = half_tick & edge_cnt[0];
  assign m_last = m_trail && (edge_cnt == sfp_pkg::LAST_EDGE);

  assign s_sel = enable & ~master & ~ss_b_i;
  assign s_rise = sck_i & ~sck_q;
  assign s_fall = ~sck_i & sck_q;
  assign s_lead = s_sel & (clock_polarity_bit ? s_fall : s_rise);
  assign s_trail = s_sel & (clock_polarity_bit ? s_rise : s_fall);
  assign s_last = s_trail && (s_bits == sfp_pkg::LAST_BIT);
  assign ss_fall = ss_q & ~ss_b_i;

  assign lead = m_lead | s_lead;
  assign trail = m_trail | s_trail;
  assign din = master ? miso_i : mosi_i;
  assign complete = m_last | s_last;
  assign overrun = done_flag;
  // Phase 1 latches on the trailing edge, phase 0 on the leading one
  assign rx_word = {sh[W-2:0], (clock_phase_bit ? din : sample_bit)};

  // Master refuses a new byte while shifting or while the stream is full
  always_comb begin
    if (!data_wr_i) begin
      wr_collide = 1'b0;
    end else if (master) begin
      wr_collide = m_active | ~rxq.push_ready;
    end else if (clock_phase_bit) begin
      wr_collide = s_busy;
    end else begin
      wr_collide = ~ss_b_i;
    end
  end

  assign load = data_wr_i & ~wr_collide;
  assign start = load & master & enable & ~mode_fault_ev;
  assign data_acc = data_wr_i | data_rd_i;

  // Control register
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      irq_en <= 1'b0;
      enable <= 1'b0;
      master <= 1'b0;
      clock_polarity_bit <= sfp_pkg::RST_CLOCK_POLARITY_BIT;
      clock_phase_bit <= sfp_pkg::RST_CLOCK_PHASE_BIT;
      rate <= sfp_pkg::RST_RATE;
    end else begin
      if (ctrl_wr_i) begin
        irq_en <= ctrl_irq_en_i;
        enable <= ctrl_enable_i;
        master <= ctrl_master_i;
        clock_polarity_bit <= ctrl_clock_polarity_bit_i;
        clock_phase_bit <= ctrl_clock_phase_bit_i;
        rate <= ctrl_rate_i;
      end
      if (mode_fault_ev) begin
        master <= 1'b0;
        enable <= 1'b0;
      end
    end
  end

  // Flags: a setting event wins over a clearing access
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      done_flag <= 1'b0;
      col_flag <= 1'b0;
      mode_fault_flag_flag <= 1'b0;
    end else begin
      if (complete) begin
        done_flag <= 1'b1;
      end else if (arm_done && data_acc) begin
        done_flag <= 1'b0;
      end
      if (wr_collide) begin
        col_flag <= 1'b1;
      end else if (arm_col && data_acc) begin
        col_flag <= 1'b0;
      end
      if (mode_fault_ev) begin
        mode_fault_flag_flag <= 1'b1;
      end else if (arm_mode_fault_flag && ctrl_wr_i) begin
        mode_fault_flag_flag <= 1'b0;
      end
    end
  end

  // Status read with a flag set arms its clear
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      arm_done <= 1'b0;
      arm_col <= 1'b0;
      arm_mode_fault_flag <= 1'b0;
    end else begin
      if (status_rd_i && done_flag) begin
        arm_done <= 1'b1;
      end else if (data_acc || !done_flag) begin
        arm_done <= 1'b0;
      end
      if (status_rd_i && col_flag) begin
        arm_col <= 1'b1;
      end else if (data_acc || !col_flag) begin
        arm_col <= 1'b0;
      end
      if (status_rd_i && mode_fault_flag_flag) begin
        arm_mode_fault_flag <= 1'b1;
      end else if (ctrl_wr_i || !mode_fault_flag_flag) begin
        arm_mode_fault_flag <= 1'b0;
      end
    end
  end

  // Master clock generator
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state <= sfp_pkg::SFP_IDLE;
      half_cnt <= '0;
      edge_cnt <= '0;
      sck_lvl <= 1'b0;
    end else begin
      case (state)
        sfp_pkg::SFP_IDLE: begin
          half_cnt <= '0;
          edge_cnt <= '0;
          sck_lvl <= 1'b0;
          if (start) begin
            state <= sfp_pkg::SFP_SHIFT;
          end
        end
        sfp_pkg::SFP_SHIFT: begin
          if (mode_fault_ev) begin
            state <= sfp_pkg::SFP_IDLE;
            sck_lvl <= 1'b0;
          end else if (half_tick) begin
            half_cnt <= '0;
            sck_lvl <= ~sck_lvl;
            edge_cnt <= edge_cnt + 1'b1;
            if (m_last) begin
              state <= sfp_pkg::SFP_IDLE;
            end
          end else begin
            half_cnt <= half_cnt + 1'b1;
          end
        end
        default: begin
          state <= sfp_pkg::SFP_IDLE;
        end
      endcase
    end
  end

  // Slave edge tracking
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sck_q <= 1'b0;
      ss_q <= 1'b1;
      s_bits <= '0;
      s_busy <= 1'b0;
    end else begin
      sck_q <= sck_i;
      ss_q <= ss_b_i;
      if (!s_sel) begin
        s_bits <= '0;
        s_busy <= 1'b0;
      end else begin
        if (s_trail) begin
          s_bits <= s_bits + 1'b1;
        end
        if (s_last) begin
          s_busy <= 1'b0;
        end else if (s_lead) begin
          s_busy <= 1'b1;
        end
      end
    end
  end

  // Shift register, most significant bit first
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sh <= sfp_pkg::RST_BYTE;
      dout <= 1'b0;
      sample_bit <= 1'b0;
    end else if (load) begin
      sh <= data_wdata_i;
      dout <= data_wdata_i[W-1];
    end else if (lead) begin
      sample_bit <= din;
      if (clock_phase_bit) begin
        dout <= sh[W-1];
      end
    end else if (trail) begin
      sh <= rx_word;
      if (!clock_phase_bit) begin
        dout <= sh[W-2];
      end
    end else if (ss_fall && !clock_phase_bit && !master) begin
      dout <= sh[W-1];
    end
  end

  // Receive buffer; an overrun keeps the old byte
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rx_buf <= sfp_pkg::RST_BYTE;
    end else if (complete && !overrun) begin
      rx_buf <= rx_word;
    end
  end

  assign rxq.push_valid = complete & ~overrun;
  assign rxq.push_data = rx_word;
  assign rxq.pop_ready = rx_ready_i;

  sfp_fifo #(
    .WIDTH(W),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .q(rxq.fifo_side)
  );

  assign rx_valid_o = rxq.pop_valid;
  assign rx_data_o = rxq.pop_data;
  assign irq_en_o = irq_en;
  assign enable_o = enable;
  assign master_o = master;
  assign clock_polarity_bit_o = clock_polarity_bit;
  assign clock_phase_bit_o = clock_phase_bit;
  assign rate_o = rate;
  assign done_flag_o = done_flag;
  assign collision_flag_o = col_flag;
  assign mode_fault_flag_o = mode_fault_flag_flag;
  assign data_rdata_o = rx_buf;
  assign irq_o = irq_en & (done_flag | mode_fault_flag_flag);
  assign sck_o = clock_polarity_bit ^ sck_lvl;
  assign sck_oe_o = enable & master;
  assign mosi_o = dout;
  assign mosi_oe_o = enable & master;
  assign miso_o = dout;
  assign miso_oe_o = s_sel;
endmodule

/* File: sfp_port_bench.sv */
`timescale 1ns/10ps
module sfp_port_bench;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ctrl_wr_i = 1'b0, ctrl_irq_en_i = 1'b0, ctrl_enable_i = 1'b0, ctrl_master_i = 1'b0;
  logic ctrl_clock_polarity_bit_i = 1'b0, ctrl_clock_phase_bit_i = 1'b0, status_rd_i = 1'b0, data_wr_i = 1'b0;
  logic data_rd_i = 1'b0, rx_ready_i = 1'b0, ss_b_i = 1'b1, m_sck = 1'b0, m_mosi = 1'b0;
  logic s_sel_b = 1'b1;
  logic [1:0] ctrl_rate_i = 2'h0;
  logic [7:0] data_wdata_i = 8'h00, s_tx = 8'h00;
  logic irq_en_o, enable_o, master_o, clock_polarity_bit_o, clock_phase_bit_o, done_flag_o, collision_flag_o;
  logic mode_fault_flag_o, irq_o, rx_valid_o, sck_o, sck_oe_o, mosi_o, mosi_oe_o;
  logic miso_o, miso_oe_o, s_miso, full;
  logic [1:0] rate_o;
  logic [7:0] data_rdata_o, rx_data_o, s_rx, got;
  int num_errors = 0, checked = 0, cycles = 0, n, k;
  int div[4] = '{2, 4, 16, 32};
  wire sck_w = sck_oe_o ? sck_o : m_sck;
  wire mosi_w = mosi_oe_o ? mosi_o : m_mosi;
  wire miso_w = miso_oe_o ? miso_o : s_miso;
  sfp_port i_sfp_port (
    .clk_i, .rst_b_i, .ctrl_wr_i, .ctrl_irq_en_i, .ctrl_enable_i, .ctrl_master_i,
    .ctrl_clock_polarity_bit_i, .ctrl_clock_phase_bit_i, .ctrl_rate_i, .irq_en_o, .enable_o, .master_o, .clock_polarity_bit_o,
    .clock_phase_bit_o, .rate_o, .status_rd_i, .done_flag_o, .collision_flag_o, .mode_fault_flag_o,
    .irq_o, .data_wr_i, .data_wdata_i, .data_rd_i, .data_rdata_o, .rx_valid_o, .rx_ready_i,
    .rx_data_o, .sck_i(sck_w), .sck_o, .sck_oe_o, .mosi_i(mosi_w), .mosi_o, .mosi_oe_o,
    .miso_i(miso_w), .miso_o, .miso_oe_o, .ss_b_i
  );
  sfp_slave_model i_sfp_slave_model (
    .sck_i(sck_w), .mosi_i(mosi_w), .sel_b_i(s_sel_b), .miso_o(s_miso),
    .clock_polarity_bit_i(clock_polarity_bit_o), .clock_phase_bit_i(clock_phase_bit_o), .tx_i(s_tx), .rx_o(s_rx)
  );
  always #4 clk_i = ~clk_i;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cfg(input logic ie, en, ms, pol, pha, input logic [1:0] r);
    @(negedge clk_i);
    {ctrl_irq_en_i, ctrl_enable_i, ctrl_master_i, ctrl_clock_polarity_bit_i, ctrl_clock_phase_bit_i} = {ie, en, ms, pol, pha};
    ctrl_rate_i = r;
    ctrl_wr_i = 1'b1;
    @(negedge clk_i);
    ctrl_wr_i = 1'b0;
  endtask
  // One master only; far side deselected while modes change
  task automatic mcfg(input logic ie, pol, pha, input logic [1:0] r);
    s_sel_b = 1'b1;
    cfg(ie, 1'b1, 1'b1, pol, pha, r);
    @(negedge clk_i);
    s_sel_b = 1'b0;
  endtask
  task automatic sr();
    @(negedge clk_i);
    status_rd_i = 1'b1;
    @(negedge clk_i);
    status_rd_i = 1'b0;
  endtask
  task automatic clr();
    sr();
    data_rd_i = 1'b1;
    @(negedge clk_i);
    data_rd_i = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input int lim, output int cnt);
    @(negedge clk_i);
    data_wdata_i = d;
    data_wr_i = 1'b1;
    cnt = 0;
    do begin
      @(negedge clk_i);
      data_wr_i = 1'b0;
      cnt++;
    end while (done_flag_o !== 1'b1 && cnt < lim);
  endtask
  // Bench as master, polarity 0 phase 1, optional write at bit w
  task automatic mshift(input logic [7:0] d, input int w, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      @(negedge clk_i);
      m_sck = 1'b1;
      m_mosi = d[i];
      data_wr_i = (i == w);
      @(negedge clk_i);
      data_wr_i = 1'b0;
      repeat (2) @(negedge clk_i);
      q[i] = miso_w;
      m_sck = 1'b0;
      repeat (3) @(negedge clk_i);
    end
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    repeat (5) @(negedge clk_i);
    rst_b_i = 1'b1;
    chk(clock_polarity_bit_o, 1'b0);
    chk(clock_phase_bit_o, 1'b1);
    for (int r = 0; r < 4; r++) begin
      s_tx = 8'h5A ^ 8'(r);
      mcfg(r[0], r[0], r[1], r[1:0]);
      xfer(8'hC0 | 8'(r), 400, n);
      chk(16'(n), 16'(div[r] * 8 + 1));
      chk(data_rdata_o, s_tx);
      chk(s_rx, 8'hC0 | 8'(r));
      chk(irq_o, r[0]);
      clr();
      chk(done_flag_o, 1'b0);
    end
    xfer(8'hC3, 1, n);
    xfer(8'h3C, 400, n);
    chk(collision_flag_o, 1'b1);
    chk(s_rx, 8'hC3);
    clr();
    chk(collision_flag_o, 1'b0);
    xfer(8'h11, 400, n);
    s_tx = 8'h96;
    xfer(8'h22, 400, n);
    repeat (300) @(negedge clk_i);
    chk(data_rdata_o, 8'h59);
    chk(s_rx, 8'h22);
    clr();
    s_sel_b = 1'b1;
    @(negedge clk_i);
    ss_b_i = 1'b0;
    @(negedge clk_i);
    ss_b_i = 1'b1;
    chk({master_o, enable_o, mode_fault_flag_o, irq_o}, 4'h3);
    sr();
    cfg(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 2'h0);
    chk(mode_fault_flag_o, 1'b0);
    xfer(8'h3C, 2, n);
    ss_b_i = 1'b0;
    mshift(8'hA5, 8, got);
    chk(got, 8'h3C);
    chk(data_rdata_o, 8'hA5);
    clr();
    // Select stays low across both bytes
    mshift(8'h5A, 4, got);
    chk(got, 8'hA5);
    chk(collision_flag_o, 1'b1);
    chk(data_rdata_o, 8'h5A);
    clr();
    ss_b_i = 1'b1;
    cfg(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 2'h0);
    ss_b_i = 1'b0;
    xfer(8'h77, 2, n);
    chk(collision_flag_o, 1'b1);
    chk(data_rdata_o, 8'h5A);
    ss_b_i = 1'b1;
    clr();
    mcfg(1'b0, 1'b0, 1'b0, 2'h0);
    k = 0;
    // Fill with the stream stalled until a write is refused
    do begin
      xfer(8'h0F, 60, n);
      k++;
      full = collision_flag_o;
      clr();
    end while (!full && k < 40);
    chk(full, 1'b1);
    chk(rx_data_o, 8'h5A);
    rx_ready_i = 1'b1;
    k = 0;
    repeat (40) begin
      if (rx_valid_o === 1'b1) k++;
      @(negedge clk_i);
    end
    chk(16'(k), 16'h0020);
    summarize();
  end
endmodule
bind sfp_port sfp_port_checker i_sfp_port_checker (
  .clk_i, .rst_b_i, .ctrl_wr_i, .status_rd_i, .data_wr_i, .data_rd_i, .ss_b_i, .irq_en_o,
  .enable_o, .master_o, .clock_polarity_bit_o, .clock_phase_bit_o, .rate_o, .done_flag_o, .collision_flag_o,
  .mode_fault_flag_o, .irq_o, .sck_oe_o, .mosi_oe_o, .miso_oe_o
);

/* File: sfp_port_checker.sv */
`timescale 1ns/10ps
module sfp_port_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Requests
  input wire logic ctrl_wr_i,
  input wire logic status_rd_i,
  input wire logic data_wr_i,
  input wire logic data_rd_i,
  input wire logic ss_b_i,
  // Readback and flags
  input wire logic irq_en_o,
  input wire logic enable_o,
  input wire logic master_o,
  input wire logic clock_polarity_bit_o,
  input wire logic clock_phase_bit_o,
  input wire logic [1:0] rate_o,
  input wire logic done_flag_o,
  input wire logic collision_flag_o,
  input wire logic mode_fault_flag_o,
  input wire logic irq_o,
  // Pin enables
  input wire logic sck_oe_o,
  input wire logic mosi_oe_o,
  input wire logic miso_oe_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  irq_mask_a:
    assert property (irq_o == (irq_en_o && (done_flag_o || mode_fault_flag_o)))
    else $error("irq does not follow mask and flags");
  reset_vals_a:
    assert property (disable iff (1'b0) !rst_b_i |=> !clock_polarity_bit_o && clock_phase_bit_o && rate_o == 2'h0)
    else $error("control fields wrong after reset");
  mode_fault_a:
    assert property (master_o && !ss_b_i |=> !master_o && !enable_o && mode_fault_flag_o)
    else $error("select low in master mode not handled");
  master_pins_a:
    assert property (sck_oe_o == (enable_o && master_o) && mosi_oe_o == sck_oe_o)
    else $error("master pin directions wrong");
  slave_pins_a:
    assert property (miso_oe_o == (enable_o && !master_o && !ss_b_i))
    else $error("slave output enable wrong");
  write_clash_a:
    assert property (master_o && enable_o && data_wr_i ##2 data_wr_i && master_o |=> collision_flag_o)
    else $error("write during transfer not flagged");
  byte_time_a:
    assert property (disable iff (!rst_b_i || !ss_b_i)
      master_o && enable_o && rate_o == 2'h0 && data_wr_i && !done_flag_o && !collision_flag_o
      ##1 !collision_flag_o |-> ##15 !done_flag_o ##1 done_flag_o)
    else $error("transfer length wrong");
  done_clear_a:
    assert property (done_flag_o && status_rd_i ##1 data_rd_i && !status_rd_i |=> !done_flag_o)
    else $error("done flag not cleared");
  fault_clear_a:
    assert property (mode_fault_flag_o && status_rd_i ##2 ctrl_wr_i && !master_o |=> !mode_fault_flag_o)
    else $error("mode fault flag not cleared");
  cover property (master_o && data_wr_i);
  cover property (mode_fault_flag_o);
  cover property (collision_flag_o && !master_o);
endmodule

/* File: sfp_slave_model.sv */
`timescale 1ns/10ps
module sfp_slave_model (
  // Serial pins
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic sel_b_i,
  output logic miso_o,
  // Mode and data
  input wire logic clock_polarity_bit_i,
  input wire logic clock_phase_bit_i,
  input wire logic [7:0] tx_i,
  output logic [7:0] rx_o
);
  int lead_cnt = 0;
  int trail_cnt = 0;
  logic [2:0] idx;
  always @(negedge sel_b_i) begin
    lead_cnt = 0;
    trail_cnt = 0;
  end
  // Slave only, never starts a byte; edges count only while selected
  always @(sck_i) begin
    if (!sel_b_i && (sck_i ^ clock_polarity_bit_i)) begin
      lead_cnt++;
      if (!clock_phase_bit_i) rx_o = {rx_o[6:0], mosi_i};
    end else if (!sel_b_i) begin
      trail_cnt++;
      if (clock_phase_bit_i) rx_o = {rx_o[6:0], mosi_i};
    end
  end
  assign idx = clock_phase_bit_i ? 3'(lead_cnt - 1) : 3'(trail_cnt);
  // Released line shows the inverse of its last bit
  assign miso_o = sel_b_i ? ~tx_i[0] : tx_i[3'h7 - idx];
endmodule
